// file: nibble_sub_borrow_logic_alu_tb.sv
// Self-checking bench for the nibble ALU slice, driven over APB.
// Assumes the slice answers with pready and holds data memory behind two registers.
`timescale 1ns/1ps
`default_nettype none

module nibble_sub_borrow_logic_alu_tb;
   logic        core_clk;
   logic        arst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd;
   logic        er;
   int          fails;
   int          total_checks;

   nsb_alu uut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Transfers run back to back: the next call opens its setup cycle at the
   // completing edge, so each signal is assigned once per edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      if (pready !== 1'b1) chk("pready", 32'h0, 32'h1);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rd & m, e);
   endtask

   task automatic setm(input logic [6:0] a, input logic [3:0] v);
      apb(1'b1, nsb_pkg::OFS_MEM_ADDR, {25'h0, a});
      apb(1'b1, nsb_pkg::OFS_MEM_DATA, {28'h0, v});
   endtask

   task automatic getm(input logic [6:0] a, input logic [3:0] e, input string nm);
      apb(1'b1, nsb_pkg::OFS_MEM_ADDR, {25'h0, a});
      rdchk(nsb_pkg::OFS_MEM_DATA, 32'hF, {28'h0, e}, nm);
   endtask

   task automatic run(input logic [4:0] op, input logic [6:0] a, input logic [3:0] opd);
      apb(1'b1, nsb_pkg::OFS_INSTR, {16'h0, op, a, opd});
   endtask

   task automatic test_bus();
      rdchk(nsb_pkg::OFS_PSW, 32'h1F, 32'h0, "psw_reset");
      rdchk(nsb_pkg::OFS_INDEX, 32'h7F, 32'h0, "index_reset");
      rdchk(nsb_pkg::OFS_RPTR, 32'h7, 32'h0, "rptr_reset");
      rdchk(nsb_pkg::OFS_STATUS, 32'h1, 32'h0, "status_reset");
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped_err", {31'h0, er}, 32'h1);
      run(5'h00, 7'h00, 4'h0);
      rdchk(nsb_pkg::OFS_STATUS, 32'h1, 32'h1, "illegal_set");
      apb(1'b1, nsb_pkg::OFS_STATUS, 32'h1);
      rdchk(nsb_pkg::OFS_STATUS, 32'h1, 32'h0, "illegal_clr");
      $display("test_bus done");
   endtask

   // Each case: memory, immediate, then flags borrow, compare, decimal, nil
   task automatic test_subtract();
      logic [11:0] cs [10] = '{12'h538, 12'h330, 12'h231, 12'h008, 12'h775,
                               12'h774, 12'h925, 12'h232, 12'h99A, 12'h522};
      logic [4:0] d;
      logic [3:0] r, m;
      logic       nil;
      for (int i = 0; i < 10; i++) begin
         m = cs[i][11:8];
         d = {1'b0, m} - {1'b0, cs[i][7:4]} - {4'h0, cs[i][3]};
         r = (cs[i][1] && d[4]) ? d[3:0] - 4'h6 : d[3:0];
         nil = (r != 4'h0) ? 1'b0 : (cs[i][2] ? cs[i][0] : 1'b1);
         apb(1'b1, nsb_pkg::OFS_PSW, {28'h0, cs[i][1], cs[i][2], cs[i][0], cs[i][3]});
         setm({3'h1, i[3:0]}, m);
         run(nsb_pkg::OPC_SUBB_IMM, {3'h1, i[3:0]}, cs[i][7:4]);
         rdchk(nsb_pkg::OFS_PSW, 32'h1F,
               {27'h0, 1'b0, cs[i][1], cs[i][2], nil, d[4]}, "sub_psw");
         getm({3'h1, i[3:0]}, cs[i][2] ? m : r, "sub_mem");
      end
      $display("test_subtract done");
   endtask

   task automatic test_logic();
      logic [4:0] ops [4] = '{nsb_pkg::OPC_OR_REG, nsb_pkg::OPC_AND_REG,
                              nsb_pkg::OPC_OR_IMM, nsb_pkg::OPC_AND_IMM};
      logic [3:0] e;
      apb(1'b1, nsb_pkg::OFS_RPTR, 32'h2);
      for (int i = 0; i < 4; i++) begin
         e = i[0] ? 4'h2 : 4'hE;
         apb(1'b1, nsb_pkg::OFS_PSW, 32'h7);
         setm(7'h23, 4'hA);
         setm(7'h5F, i[1] ? 4'hA : 4'h6);
         run(ops[i], 7'h5F, i[1] ? 4'h6 : 4'h3);
         getm(7'h23, i[1] ? 4'hA : e, "logic_reg");
         getm(7'h5F, i[1] ? e : 4'h6, "logic_mem");
         rdchk(nsb_pkg::OFS_PSW, 32'h1F, 32'h7, "logic_flags");
      end
      $display("test_logic done");
   endtask

   task automatic test_index();
      apb(1'b1, nsb_pkg::OFS_INDEX, 32'h40);
      apb(1'b1, nsb_pkg::OFS_PSW, 32'h10);
      setm(7'h2F, 4'h1);
      setm(7'h6F, 4'h8);
      run(nsb_pkg::OPC_SUBB_IMM, 7'h2F, 4'h5);
      getm(7'h6F, 4'h3, "index_target");
      getm(7'h2F, 4'h1, "index_base");
      $display("test_index done");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #100000;
      fails++;
      finish_test();
   end

   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fails = 0;
      total_checks = 0;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      test_bus();
      test_subtract();
      test_logic();
      test_index();
      finish_test();
   end
endmodule // nibble_sub_borrow_logic_alu_tb

`default_nettype wire

// file: nsb_alu.sv
// Four-bit ALU slice with its data memory, flags and APB register file.
// Assumes an APB master on core_clk; instructions are issued by writing
// the instruction register and run in the cycle after that write.
`timescale 1ns/1ps
`default_nettype none

module nsb_alu (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   nsb_pkg::nsb_state_t state;
   logic [15:0] instr;
   logic        borrow_flag;
   logic        nil_flag;
   logic        compare_flag;
   logic        decimal_mode;
   logic        index_enable;
   logic [6:0]  index_register;
   logic [2:0]  reg_pointer;
   logic [6:0]  mem_addr;
   logic        illegal_op;
   logic [3:0]  last_result;
   logic [3:0]  dmem [nsb_pkg::DMEM_WORDS];

   logic [4:0]  opcode;
   logic [2:0]  memory_row_field;
   logic [3:0]  memory_column_field;
   logic [3:0]  immediate_nibble;
   logic [6:0]  eff_addr;
   logic [6:0]  reg_addr;
   logic [3:0]  mem_rd;
   logic [3:0]  reg_rd;
   logic [3:0]  sub_res;
   logic        sub_borrow;
   logic        is_sub;
   logic        is_reg_dst;
   logic        is_mem_logic;
   logic        is_legal;
   logic [3:0]  logic_res;
   logic        exec;
   logic        apb_wr;
   logic        apb_rd;
   logic        mapped;
   logic        rd_retry;

   // Returns {borrow, difference}; decimal mode wraps to 0..9 digits
   function automatic logic [4:0] nsb_sub(input logic [3:0] a, input logic [3:0] b,
                                          input logic bin, input logic dec);
      logic [4:0] d;
      logic [3:0] r;
      d = {1'b0, a} - {1'b0, b} - {4'h0, bin};
      r = d[3:0];
      if (dec && d[4]) begin
         r = d[3:0] - nsb_pkg::DEC_ADJUST;
      end
      return {d[4], r};
   endfunction

   // Instruction fields
   assign opcode              = instr[nsb_pkg::OPC_HI:nsb_pkg::OPC_LO];
   assign memory_row_field    = instr[nsb_pkg::ROW_HI:nsb_pkg::ROW_LO];
   assign memory_column_field = instr[nsb_pkg::COL_HI:nsb_pkg::COL_LO];
   assign immediate_nibble    = instr[nsb_pkg::OPD_HI:nsb_pkg::OPD_LO];

   // Index modification touches only the memory operand, never the register one
   assign eff_addr = {memory_row_field, memory_column_field}
                     | (index_enable ? index_register : 7'h00);
   assign reg_addr = {reg_pointer, immediate_nibble};
   assign mem_rd   = dmem[eff_addr];
   assign reg_rd   = dmem[reg_addr];

   assign is_sub       = (opcode == nsb_pkg::OPC_SUBB_IMM);
   assign is_reg_dst   = (opcode == nsb_pkg::OPC_OR_REG) || (opcode == nsb_pkg::OPC_AND_REG);
   assign is_mem_logic = (opcode == nsb_pkg::OPC_OR_IMM) || (opcode == nsb_pkg::OPC_AND_IMM);
   assign is_legal     = is_sub || is_reg_dst || is_mem_logic;

   assign {sub_borrow, sub_res} = nsb_sub(mem_rd, immediate_nibble, borrow_flag, decimal_mode);

   always_comb begin
      unique case (opcode)
         nsb_pkg::OPC_OR_REG:  logic_res = reg_rd | mem_rd;
         nsb_pkg::OPC_OR_IMM:  logic_res = mem_rd | immediate_nibble;
         nsb_pkg::OPC_AND_REG: logic_res = reg_rd & mem_rd;
         nsb_pkg::OPC_AND_IMM: logic_res = mem_rd & immediate_nibble;
         default:              logic_res = 4'h0;
      endcase
   end

   assign exec    = (state == nsb_pkg::NSB_EXEC);
   // A read set up in the execute cycle latched pre-execute data, so its
   // access waits one cycle while prdata reloads
   assign pready  = !exec && !rd_retry;
   assign apb_wr  = psel && penable && pwrite && pready;
   assign apb_rd  = psel && penable && !pwrite && pready;

   always_comb begin
      mapped = 1'b1;
      unique case (paddr)
         nsb_pkg::OFS_INSTR, nsb_pkg::OFS_PSW, nsb_pkg::OFS_INDEX, nsb_pkg::OFS_RPTR,
         nsb_pkg::OFS_MEM_ADDR, nsb_pkg::OFS_MEM_DATA, nsb_pkg::OFS_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !mapped;

   // Marks a read whose setup overlapped the execute cycle; without it a
   // back-to-back read would return flags and memory from before the instruction
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_retry <= 1'b0;
      end else begin
         rd_retry <= psel && !penable && !pwrite && exec;
      end
   end

   // Sequencer: one execute cycle per issued instruction
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= nsb_pkg::NSB_IDLE;
      end else begin
         unique case (state)
            nsb_pkg::NSB_IDLE: begin
               if (apb_wr && paddr == nsb_pkg::OFS_INSTR) begin
                  state <= nsb_pkg::NSB_EXEC;
               end
            end
            nsb_pkg::NSB_EXEC: state <= nsb_pkg::NSB_IDLE;
         endcase
      end
   end

   // Software-visible configuration
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         instr          <= nsb_pkg::RST_INSTR;
         index_register <= nsb_pkg::RST_INDEX;
         reg_pointer    <= nsb_pkg::RST_RPTR;
         mem_addr       <= nsb_pkg::RST_ADDR;
         compare_flag   <= 1'b0;
         decimal_mode   <= 1'b0;
         index_enable   <= 1'b0;
      end else if (apb_wr) begin
         unique case (paddr)
            nsb_pkg::OFS_INSTR:    instr          <= pwdata[15:0];
            nsb_pkg::OFS_INDEX:    index_register <= pwdata[6:0];
            nsb_pkg::OFS_RPTR:     reg_pointer    <= pwdata[2:0];
            nsb_pkg::OFS_MEM_ADDR: mem_addr       <= pwdata[6:0];
            nsb_pkg::OFS_PSW: begin
               compare_flag <= pwdata[nsb_pkg::PSW_COMPARE];
               decimal_mode <= pwdata[nsb_pkg::PSW_DECIMAL];
               index_enable <= pwdata[nsb_pkg::PSW_INDEX];
            end
            default: ;
         endcase
      end
   end

   // Borrow and nil flags: written by software when idle, by the subtract otherwise
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         borrow_flag <= 1'b0;
         nil_flag    <= 1'b0;
      end else if (exec && is_sub) begin
         borrow_flag <= sub_borrow;
         if (sub_res != 4'h0) begin
            nil_flag <= 1'b0;
         end else if (!compare_flag) begin
            nil_flag <= 1'b1;
         end
      end else if (apb_wr && paddr == nsb_pkg::OFS_PSW) begin
         borrow_flag <= pwdata[nsb_pkg::PSW_BORROW];
         nil_flag    <= pwdata[nsb_pkg::PSW_NIL];
      end
   end

   // Logical operations never reach the flag process above

   // Status: illegal opcode is sticky, write one clears, a new event wins
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         illegal_op  <= 1'b0;
         last_result <= 4'h0;
      end else begin
         if (exec && !is_legal) begin
            illegal_op <= 1'b1;
         end else if (apb_wr && paddr == nsb_pkg::OFS_STATUS && pwdata[nsb_pkg::STS_ILLEGAL]) begin
            illegal_op <= 1'b0;
         end
         if (exec && is_sub) begin
            last_result <= sub_res;
         end else if (exec && is_legal) begin
            last_result <= logic_res;
         end
      end
   end

   // Data memory; not reset, software initialises it
   always_ff @(posedge core_clk) begin
      if (exec && is_sub && !compare_flag) begin
         dmem[eff_addr] <= sub_res;
      end else if (exec && is_mem_logic) begin
         dmem[eff_addr] <= logic_res;
      end else if (exec && is_reg_dst) begin
         dmem[reg_addr] <= logic_res;
      end else if (apb_wr && paddr == nsb_pkg::OFS_MEM_DATA) begin
         dmem[mem_addr] <= pwdata[3:0];
      end
   end

   // Read data: loaded in setup and again in every stalled access cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !pwrite && !(penable && pready)) begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            nsb_pkg::OFS_INSTR:    prdata <= {16'h0000, instr};
            nsb_pkg::OFS_PSW:      prdata <= {27'h0, index_enable, decimal_mode,
                                              compare_flag, nil_flag, borrow_flag};
            nsb_pkg::OFS_INDEX:    prdata <= {25'h0, index_register};
            nsb_pkg::OFS_RPTR:     prdata <= {29'h0, reg_pointer};
            nsb_pkg::OFS_MEM_ADDR: prdata <= {25'h0, mem_addr};
            nsb_pkg::OFS_MEM_DATA: prdata <= {28'h0, dmem[mem_addr]};
            nsb_pkg::OFS_STATUS:   prdata <= {24'h0, last_result, 3'h0, illegal_op};
            default:               prdata <= 32'h0000_0000;
         endcase
      end
   end

   a_sub_store: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub && !compare_flag |=> dmem[$past(eff_addr)] == $past(sub_res))
      else $error("subtract result not stored");

   a_compare_keep: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub && compare_flag |=> dmem[$past(eff_addr)] == $past(mem_rd))
      else $error("compare mode changed memory");

   a_borrow_upd: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub && mem_rd < immediate_nibble |=> borrow_flag)
      else $error("borrow not set");

   a_nil_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub && sub_res != 4'h0 |=> !nil_flag)
      else $error("nil flag not cleared");

   a_nil_set: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub && sub_res == 4'h0 && !compare_flag |=> nil_flag)
      else $error("nil flag not set");

   a_nil_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub && sub_res == 4'h0 && compare_flag |=> $stable(nil_flag))
      else $error("nil flag changed in compare");

   a_dec_digit: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub && decimal_mode && mem_rd <= nsb_pkg::DEC_MAX
      && immediate_nibble <= nsb_pkg::DEC_MAX |-> sub_res <= nsb_pkg::DEC_MAX)
      else $error("decimal result out of range");

   a_or_reg: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && opcode == nsb_pkg::OPC_OR_REG |=> dmem[$past(reg_addr)] == ($past(reg_rd) | $past(mem_rd)))
      else $error("register OR wrong");

   a_and_imm: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && opcode == nsb_pkg::OPC_AND_IMM
      |=> dmem[$past(eff_addr)] == ($past(mem_rd) & $past(immediate_nibble)))
      else $error("immediate AND wrong");

   a_logic_flags: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && (is_reg_dst || is_mem_logic) |=> $stable(borrow_flag) && $stable(nil_flag)
      && $stable(compare_flag))
      else $error("logical op changed flags");

   a_index_addr: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && index_enable |-> (eff_addr & index_register) == index_register)
      else $error("index bits missing from address");

   a_index_off: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && !index_enable
      |-> eff_addr == {memory_row_field, memory_column_field})
      else $error("address modified with index disabled");

   a_borrow_clr: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub && ({1'b0, mem_rd} >= ({1'b0, immediate_nibble} + {4'h0, borrow_flag}))
      |=> !borrow_flag)
      else $error("borrow not cleared");

   a_bin_diff: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub && !decimal_mode && !compare_flag
      |=> dmem[$past(eff_addr)]
          == 4'($past(mem_rd) - $past(immediate_nibble) - $past(borrow_flag)))
      else $error("binary difference wrong");

   a_compare_stays: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_sub
      |=> compare_flag == $past(compare_flag))
      else $error("subtract changed compare flag");

   a_or_imm: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && opcode == nsb_pkg::OPC_OR_IMM
      |=> dmem[$past(eff_addr)] == ($past(mem_rd) | $past(immediate_nibble)))
      else $error("immediate OR wrong");

   a_and_reg: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && opcode == nsb_pkg::OPC_AND_REG
      |=> dmem[$past(reg_addr)] == ($past(reg_rd) & $past(mem_rd)))
      else $error("register AND wrong");

   a_reg_src_keep: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && is_reg_dst && reg_addr != eff_addr
      |=> dmem[$past(eff_addr)] == $past(mem_rd))
      else $error("register op changed its memory operand");

   a_illegal_set: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && !is_legal |=> illegal_op)
      else $error("unknown opcode not flagged");

endmodule // nsb_alu

`default_nettype wire

// file: nsb_pkg.sv
// Constants shared by the nibble ALU slice: register offsets, field layout,
// opcodes and reset values. Assumes a 32-bit APB register bus.
`default_nettype none

package nsb_pkg;

   // APB byte offsets
   localparam logic [7:0] OFS_INSTR    = 8'h00;
   localparam logic [7:0] OFS_PSW      = 8'h04;
   localparam logic [7:0] OFS_INDEX    = 8'h08;
   localparam logic [7:0] OFS_RPTR     = 8'h0C;
   localparam logic [7:0] OFS_MEM_ADDR = 8'h10;
   localparam logic [7:0] OFS_MEM_DATA = 8'h14;
   localparam logic [7:0] OFS_STATUS   = 8'h18;

   // Instruction word fields
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 11;
   localparam int ROW_HI = 10;
   localparam int ROW_LO = 8;
   localparam int COL_HI = 7;
   localparam int COL_LO = 4;
   localparam int OPD_HI = 3;
   localparam int OPD_LO = 0;

   // Program status word bit positions
   localparam int PSW_BORROW  = 0;
   localparam int PSW_NIL     = 1;
   localparam int PSW_COMPARE = 2;
   localparam int PSW_DECIMAL = 3;
   localparam int PSW_INDEX   = 4;

   // Status register bit positions
   localparam int STS_ILLEGAL = 0;
   localparam int STS_RES_LO  = 4;

   // Opcodes
   localparam logic [4:0] OPC_SUBB_IMM = 5'h13;
   localparam logic [4:0] OPC_OR_REG   = 5'h06;
   localparam logic [4:0] OPC_OR_IMM   = 5'h16;
   localparam logic [4:0] OPC_AND_REG  = 5'h04;
   localparam logic [4:0] OPC_AND_IMM  = 5'h14;

   localparam int         DMEM_WORDS   = 128;
   localparam logic [3:0] DEC_ADJUST   = 4'h6;
   localparam logic [3:0] DEC_MAX      = 4'h9;

   // Reset values
   localparam logic [15:0] RST_INSTR   = 16'h0000;
   localparam logic [6:0]  RST_INDEX   = 7'h00;
   localparam logic [2:0]  RST_RPTR    = 3'h0;
   localparam logic [6:0]  RST_ADDR    = 7'h00;

   typedef enum logic {
      NSB_IDLE = 1'b0,
      NSB_EXEC = 1'b1
   } nsb_state_t;

endpackage

`default_nettype wire
